// ### verif/indexer_status_and_flag_logic_test.sv
// Self-checking bench of the sequence status and flag logic
`timescale 1ns/1ps
`include "seq_status_params.svh"
module indexer_status_and_flag_logic_test;
   import seq_status_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic clk_en = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, reply_ready, reply_valid, slow = 1'b0;
   logic [5:0] ev = 6'h00;
   logic [7:0] reply_char, user_flag;
   logic decel_req, flush_queue, save_req, cond_skip, panel_fault;
   logic [31:0] rv;
   logic re;
   int n_fail = 0;
   int tests_run = 0;
   int nd = 0;
   int nf = 0;
   int ns = 0;
   int base;
   initial forever #4 pclk = ~pclk;
   seq_status DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .power_up_launch(ev[5]), .limit_hit(ev[4]),
      .end_of_travel(ev[3]), .loop_open(ev[2]), .loop_close(ev[1]),
      .seq_boundary(ev[0]), .reply_ready(reply_ready),
      .reply_char(reply_char), .reply_valid(reply_valid),
      .decel_req(decel_req), .flush_queue(flush_queue),
      .save_req(save_req), .cond_skip(cond_skip),
      .panel_fault(panel_fault), .user_flag(user_flag));
   reply_sink SINK (.pclk(pclk), .presetn(presetn), .slow(slow),
      .reply_char(reply_char), .reply_valid(reply_valid),
      .reply_ready(reply_ready));
   always @(posedge pclk)
   begin
      nd += (decel_req === 1'b1);
      nf += (flush_queue === 1'b1);
      ns += (save_req === 1'b1);
   end
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 20; k++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      rv = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Outputs launched at the access edge are settled here
      @(negedge pclk);
      if (k == 20)
      begin
         n_fail++;
         report_and_stop();
      end
   endtask
   function automatic logic [31:0] pat(input logic [3:0] len,
      input logic [7:0] v, input logic [7:0] m);
      return {m, v, 4'b0, len, 8'h00};
   endfunction
   task automatic cmd(input cmd_t c, input logic [31:0] p);
      apb(1'b1, `REG_CMD, p | {28'h0, c});
   endtask
   task automatic fire(input logic [5:0] v);
      @(posedge pclk);
      ev <= v;
      @(posedge pclk);
      ev <= 6'h00;
   endtask
   task automatic st(input logic [2:0] exp);
      apb(1'b0, `REG_STATUS, 32'h0);
      chk(rv[2:0], exp);
   endtask
   task automatic query(input cmd_t c, input int len);
      int k;
      base = SINK.n;
      cmd(c, 32'h0);
      // Next query only after the full reply
      for (k = 0; k < 300 && SINK.n < base + len; k++)
         @(posedge pclk);
      if (k == 300)
      begin
         n_fail++;
         report_and_stop();
      end
   endtask
   task automatic got(input int i, input logic [7:0] exp);
      chk({24'h0, SINK.got[base + i]}, {24'h0, exp});
   endtask
   task automatic t_reset();
      chk(user_flag, 8'h00);
      apb(1'b0, `REG_STATUS, 32'h0);
      chk(rv[15:8], `FAULT_NONE);
      apb(1'b0, 12'h100, 32'hFFFF_FFFF);
      chk({31'h0, re}, 32'h0000_0001);
      chk(rv, 32'h0000_0000);
   endtask
   task automatic t_flags();
      cmd(CMD_FLAG_WRITE, pat(4'd2, 8'hC0, 8'hC0));
      chk(user_flag, 8'hC0);
      cmd(CMD_FLAG_WRITE, pat(4'd7, 8'h0B, 8'h0F));
      chk(user_flag, 8'hCA);
      cmd(CMD_FLAG_WRITE, pat(4'd4, 8'h00, 8'hFF));
      apb(1'b0, `REG_FLAG_PAT, 32'h0);
      chk(rv[7:0], 8'h0A);
      cmd(CMD_FLAG_TEST, pat(4'd7, 8'h0A, 8'h0E));
      chk(cond_skip, 1'b0);
      cmd(CMD_FLAG_TEST, pat(4'd7, 8'h04, 8'h0E));
      apb(1'b0, `REG_FLAG_MASK, 32'h0);
      chk(rv[0], 1'b1);
      cmd(CMD_END_COND, 32'h0);
      chk(cond_skip, 1'b0);
      cmd(CMD_FLAG_WRITE, pat(4'd8, 8'h01, 8'h01));
      chk(user_flag, 8'h0B);
      cmd(CMD_FLAG_WRITE, pat(4'd0, 8'hFF, 8'hFF));
      chk(user_flag, 8'h0B);
   endtask
   task automatic t_seq();
      cmd(CMD_RUN, 32'h0);
      st(3'b001);
      cmd(CMD_END_MARK, 32'h0);
      st(3'b010);
      fire(6'h20);
      st(3'b001);
      cmd(CMD_STOP, 32'h0);
      st(3'b010);
      cmd(CMD_RUN_VAR, 32'h0);
      slow <= 1'b1;
      query(CMD_Q_STATE, 3);
      got(0, `CH_STAR);
      got(1, 8'h41);
      got(2, `CH_CR);
      cmd(CMD_KILL, 32'h0);
      st(3'b010);
      cmd(CMD_RUN, 32'h0);
      fire(6'h10);
      st(3'b010);
      cmd(CMD_RUN, 32'h0);
      fire(6'h08);
      st(3'b010);
      apb(1'b1, `REG_LOOP, 32'h0);
      fire(6'h04);
      cmd(CMD_RUN, 32'h0);
      apb(1'b0, `REG_STATUS, 32'h0);
      chk(rv[0], 1'b0);
      fire(6'h02);
      fire(6'h04);
      fire(6'h01);
      fire(6'h02);
      apb(1'b0, `REG_STATUS, 32'h0);
      chk(rv[2], 1'b1);
      query(CMD_Q_STATE, 3);
      got(1, `CH_BADLOOP);
      apb(1'b1, `REG_LOOP, 32'h0);
      slow <= 1'b0;
   endtask
   task automatic t_fault();
      logic [7:0] codes [0:5] = '{`FAULT_POS, `FAULT_CUR, `FAULT_PLUG,
         `FAULT_CSUM, `FAULT_SHUT, `FAULT_STEP};
      logic [5:0] shown = 6'b10_1111;
      apb(1'b1, `REG_CTRL, 32'h2);
      for (int i = 0; i < 6; i++)
      begin
         apb(1'b1, `REG_FAULT_IN, 32'h1 << i);
         apb(1'b0, `REG_STATUS, 32'h0);
         chk(rv[15:8], codes[i]);
         chk(panel_fault, shown[i]);
      end
      apb(1'b1, `REG_FAULT_IN, 32'h2);
      query(CMD_Q_FAULT, 3);
      got(0, 8'h32);
      got(1, 8'h32);
      got(2, `CH_CR);
      apb(1'b1, `REG_FAULT_IN, 32'h0);
      st(3'b010);
      chk(rv[15:8], `FAULT_NONE);
   endtask
   task automatic halt_case(input logic [31:0] ctrl, input cmd_t c,
      input int dd, input int df);
      int d0;
      int f0;
      apb(1'b1, `REG_CTRL, ctrl);
      d0 = nd;
      f0 = nf;
      cmd(c, 32'h0);
      idle(4);
      chk(nd - d0, dd);
      chk(nf - f0, df);
   endtask
   task automatic t_halt();
      int s0;
      halt_case(32'h0, CMD_HALT, 1, 1);
      halt_case(32'h1, CMD_HALT, 1, 0);
      halt_case(32'h4, CMD_HALT, 0, 0);
      cmd(CMD_EXIT_STREAM, 32'h0);
      idle(4);
      chk(nd, 3);
      apb(1'b0, `REG_CTRL, 32'h0);
      chk(rv[2], 1'b0);
      apb(1'b0, `REG_SAVE_CNT, 32'h0);
      s0 = rv;
      cmd(CMD_SAVE, 32'h0);
      cmd(CMD_SAVE_LONG, 32'h0);
      idle(4);
      chk(ns, 2);
      apb(1'b0, `REG_SAVE_CNT, 32'h0);
      chk(rv - s0, 2);
   endtask
   task automatic t_rev();
      query(CMD_Q_REV, 16);
      got(0, `CH_STAR);
      got(15, `CH_CR);
   endtask
   task automatic t_freeze();
      clk_en <= 1'b0;
      fire(6'h20);
      clk_en <= 1'b1;
      st(3'b010);
      fire(6'h20);
      st(3'b001);
   endtask
   initial
   begin
      idle(2);
      presetn <= 1'b1;
      t_reset();
      t_flags();
      t_seq();
      t_fault();
      t_halt();
      t_rev();
      t_freeze();
      report_and_stop();
   end
endmodule

// ### verif/reply_sink.sv
// Serial-side receiver model that takes reply characters
`timescale 1ns/1ps
module reply_sink (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic slow,
   input wire logic [7:0] reply_char,
   input wire logic reply_valid,
   output logic reply_ready
);
   logic [7:0] got [0:255];
   int n;
   logic phase;
   // Slow mode accepts only every other cycle
   assign reply_ready = slow ? phase : 1'b1;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         n <= 0;
         phase <= 1'b0;
      end
      else
      begin
         phase <= ~phase;
         if (reply_valid === 1'b1 && reply_ready)
         begin
            got[n[7:0]] <= reply_char;
            n <= n + 1;
         end
      end
   end
endmodule

// ### verilog/seq_status.sv
// Sequence status, fault report, halt control and user flags over APB
`timescale 1ns/1ps
`include "seq_status_params.svh"
module seq_status #(
   parameter int NUM_FLAGS = 8,
   parameter logic [31:0] REV_HI = 32'h0000_0000,
   parameter logic [31:0] REV_LO = 32'h0000_0000
)(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic power_up_launch,
   input wire logic limit_hit,
   input wire logic end_of_travel,
   input wire logic loop_open,
   input wire logic loop_close,
   input wire logic seq_boundary,
   input wire logic reply_ready,
   output logic [7:0] reply_char,
   output logic reply_valid,
   output logic decel_req,
   output logic flush_queue,
   output logic save_req,
   output logic cond_skip,
   output logic panel_fault,
   output logic [NUM_FLAGS-1:0] user_flag
);
   import seq_status_pkg::*;
   if (NUM_FLAGS != 8)
      $error("NUM_FLAGS must be 8");
   // Revision text: decimal digits, or Z for nibbles above 9, plus one suffix letter, from the parameters
   function automatic logic [7:0] hexch(input logic [3:0] n);
      hexch = (n < 4'hA) ? {4'h3, n} : 8'h5A;
   endfunction
   function automatic logic [7:0] rev_char(input logic [4:0] i);
      case (i)
         5'd0: rev_char = `CH_STAR;
         5'd1: rev_char = hexch(REV_HI[31:28]);
         5'd2: rev_char = hexch(REV_HI[27:24]);
         5'd3: rev_char = 8'h2D;
         5'd4: rev_char = hexch(REV_HI[23:20]);
         5'd5: rev_char = hexch(REV_HI[19:16]);
         5'd6: rev_char = hexch(REV_HI[15:12]);
         5'd7: rev_char = hexch(REV_HI[11:8]);
         5'd8: rev_char = hexch(REV_HI[7:4]);
         5'd9: rev_char = hexch(REV_HI[3:0]);
         5'd10: rev_char = 8'h2D;
         5'd11: rev_char = hexch(REV_LO[15:12]);
         5'd12: rev_char = hexch(REV_LO[11:8]);
         5'd13: rev_char = {1'b0, REV_LO[6:0]} | 8'h41;
         5'd14: rev_char = hexch(REV_LO[3:0]);
         default: rev_char = `CH_CR;
      endcase
   endfunction

   logic [2:0] ctrl, next_ctrl;
   logic [7:0] fault_in, next_fault_in;
   logic started, next_started;
   logic ended, next_ended;
   logic bad_loop, next_bad_loop;
   logic signed [7:0] loop_depth, next_loop_depth;
   logic [15:0] save_cnt, next_save_cnt;
   logic [NUM_FLAGS-1:0] next_user_flag;
   logic next_decel, next_flush, next_save, next_skip, next_panel;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   reply_state_t rstate, next_rstate;
   logic [1:0] rkind, next_rkind;
   logic [4:0] ridx, next_ridx;
   logic [7:0] next_reply_char;
   logic next_reply_valid;
   logic [7:0] fault_code;

   wire logic setup = psel && !penable;
   wire logic acc = psel && penable && pready;
   wire logic wr = acc && pwrite;
   wire logic cmd_wr = wr && paddr == `REG_CMD;
   cmd_t cmd;
   assign cmd = cmd_t'(pwdata[3:0]);
   wire logic stream = ctrl[`CTRL_STREAM_BIT];
   wire logic [3:0] pat_len = pwdata[11:8];

   // Fault priority: lowest-numbered fault_in bit reported
   always_comb
   begin
      fault_code = `FAULT_NONE;
      if (fault_in[0])
         fault_code = `FAULT_POS;
      else if (fault_in[1])
         fault_code = `FAULT_CUR;
      else if (fault_in[2])
         fault_code = `FAULT_PLUG;
      else if (fault_in[3])
         fault_code = `FAULT_CSUM;
      else if (fault_in[4])
         fault_code = `FAULT_SHUT;
      else if (fault_in[5] && ctrl[`CTRL_NONIDX_BIT])
         fault_code = `FAULT_STEP;
   end

   // Sequence, flag and control state
   always_comb
   begin
      logic launch;
      logic valid_seq;
      logic [7:0] mask;
      launch = 1'b0;
      valid_seq = !bad_loop && loop_depth == 8'sd0;
      mask = 8'h00;
      next_ctrl = ctrl;
      next_fault_in = fault_in;
      next_started = started;
      next_ended = ended;
      next_bad_loop = bad_loop;
      next_loop_depth = loop_depth;
      next_save_cnt = save_cnt;
      next_user_flag = user_flag;
      next_decel = 1'b0;
      next_flush = 1'b0;
      next_save = 1'b0;
      next_skip = cond_skip;
      // Clear first so a loop event in the same cycle still counts
      if (wr && paddr == `REG_LOOP)
      begin
         next_bad_loop = 1'b0;
         next_loop_depth = 8'sd0;
      end
      if (loop_open)
         next_loop_depth = next_loop_depth + 8'sd1;
      if (loop_close)
      begin
         if (next_loop_depth == 8'sd0)
            next_bad_loop = 1'b1;
         else
            next_loop_depth = next_loop_depth - 8'sd1;
      end
      if (seq_boundary && !loop_open && !loop_close)
      begin
         if (next_loop_depth != 8'sd0)
            next_bad_loop = 1'b1;
         next_loop_depth = 8'sd0;
      end
      if (power_up_launch && valid_seq)
         launch = 1'b1;
      if (wr && paddr == `REG_CTRL)
         next_ctrl = pwdata[2:0];
      if (wr && paddr == `REG_FAULT_IN)
         next_fault_in = pwdata[7:0];
      if (cmd_wr)
      begin
         case (cmd)
            CMD_RUN, CMD_RUN_VAR:
               if (valid_seq)
                  launch = 1'b1;
            CMD_STOP, CMD_KILL:
            begin
               next_started = 1'b0;
               next_ended = 1'b1;
            end
            CMD_END_MARK:
            begin
               next_started = 1'b0;
               next_ended = 1'b1;
               next_skip = 1'b0;
            end
            CMD_HALT:
               if (!stream)
               begin
                  next_decel = 1'b1;
                  next_flush = !ctrl[`CTRL_KEEP_BIT];
               end
            CMD_EXIT_STREAM:
            begin
               next_decel = 1'b1;
               next_ctrl[`CTRL_STREAM_BIT] = 1'b0;
            end
            CMD_SAVE, CMD_SAVE_LONG:
            begin
               next_save = 1'b1;
               next_save_cnt = save_cnt + 16'h0001;
            end
            CMD_FLAG_WRITE:
            begin
               // Pattern bit 7 is flag 8, first character
               for (int i = 0; i < 8; i++)
                  mask[7-i] = 4'(i) < pat_len;
               mask = mask & pwdata[31:24];
               next_user_flag = (user_flag & ~mask) |
                  (pwdata[23:16] & mask);
            end
            CMD_FLAG_TEST:
               next_skip = ((user_flag ^ pwdata[23:16]) &
                  pwdata[31:24]) != 8'h00;
            CMD_END_COND:
               next_skip = 1'b0;
            default: ;
         endcase
      end
      if (limit_hit || end_of_travel)
      begin
         next_started = 1'b0;
         next_ended = 1'b1;
      end
      if (launch)
      begin
         next_started = 1'b1;
         next_ended = 1'b0;
      end
      next_panel = fault_code != `FAULT_NONE &&
         fault_code != `FAULT_SHUT;
   end

   // APB slave: one wait-free access phase
   always_comb
   begin
      next_pready = setup;
      next_pslverr = 1'b0;
      next_prdata = 32'h0000_0000;
      if (setup)
      begin
         case (paddr)
            `REG_CTRL: next_prdata = {29'h0, ctrl};
            `REG_CMD: next_prdata = 32'h0000_0000;
            `REG_FLAG_PAT: next_prdata = {24'h0, user_flag};
            `REG_FLAG_MASK: next_prdata = {31'h0, cond_skip};
            `REG_STATUS: next_prdata = {16'h0, fault_code, 5'h0,
               bad_loop, ended, started};
            `REG_FAULT_IN: next_prdata = {24'h0, fault_in};
            `REG_REPLY: next_prdata = {22'h0, rstate == RP_SEND,
               reply_valid, reply_char};
            `REG_LOOP: next_prdata = {24'h0, loop_depth};
            `REG_SAVE_CNT: next_prdata = {16'h0, save_cnt};
            default: next_pslverr = 1'b1;
         endcase
      end
   end

   // Reply stream toward the serial side
   always_comb
   begin
      next_rstate = rstate;
      next_rkind = rkind;
      next_ridx = ridx;
      next_reply_char = reply_char;
      next_reply_valid = reply_valid;
      case (rstate)
         RP_IDLE:
            if (cmd_wr && (cmd == CMD_Q_STATE || cmd == CMD_Q_FAULT ||
               cmd == CMD_Q_REV))
            begin
               next_rstate = RP_SEND;
               next_rkind = cmd[1:0];
               next_ridx = 5'd0;
               next_reply_valid = 1'b1;
               next_reply_char = cmd == CMD_Q_FAULT ?
                  hexch(fault_code[7:4]) : `CH_STAR;
            end
         RP_SEND:
            if (reply_ready)
            begin
               next_ridx = ridx + 5'd1;
               if (reply_char == `CH_CR)
               begin
                  next_rstate = RP_IDLE;
                  next_reply_valid = 1'b0;
               end
               else if (rkind == 2'b01)
                  next_reply_char = ridx == 5'd0 ?
                     (bad_loop ? `CH_BADLOOP :
                      (`CH_AT | {6'h0, ended, started})) : `CH_CR;
               else if (rkind == 2'b10)
                  next_reply_char = ridx == 5'd0 ?
                     hexch(fault_code[3:0]) : `CH_CR;
               else
                  next_reply_char = rev_char(ridx + 5'd1);
            end
         default:
            next_rstate = RP_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl <= 3'h0;
         fault_in <= 8'h00;
         started <= 1'b0;
         ended <= 1'b0;
         bad_loop <= 1'b0;
         loop_depth <= 8'sd0;
         save_cnt <= 16'h0000;
         user_flag <= '0;
         decel_req <= 1'b0;
         flush_queue <= 1'b0;
         save_req <= 1'b0;
         cond_skip <= 1'b0;
         panel_fault <= 1'b0;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         rstate <= RP_IDLE;
         rkind <= 2'b00;
         ridx <= 5'd0;
         reply_char <= 8'h00;
         reply_valid <= 1'b0;
      end
      else if (clk_en)
      begin
         ctrl <= next_ctrl;
         fault_in <= next_fault_in;
         started <= next_started;
         ended <= next_ended;
         bad_loop <= next_bad_loop;
         loop_depth <= next_loop_depth;
         save_cnt <= next_save_cnt;
         user_flag <= next_user_flag;
         decel_req <= next_decel;
         flush_queue <= next_flush;
         save_req <= next_save;
         cond_skip <= next_skip;
         panel_fault <= next_panel;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
         rstate <= next_rstate;
         rkind <= next_rkind;
         ridx <= next_ridx;
         reply_char <= next_reply_char;
         reply_valid <= next_reply_valid;
      end
   end

   property p_launch_clears_ended;
      @(posedge pclk) disable iff (!presetn)
      clk_en && cmd_wr && cmd == CMD_RUN && !bad_loop && loop_depth == 0
      |=> started && !ended;
   endproperty
   a_launch_clears_ended: assert property (p_launch_clears_ended)
      else $error("launch did not set started and clear ended");
   property p_stop;
      @(posedge pclk) disable iff (!presetn)
      clk_en && cmd_wr && cmd == CMD_STOP && !power_up_launch
      |=> !started && ended;
   endproperty
   a_stop: assert property (p_stop)
      else $error("stop did not end sequence");
   property p_limit;
      @(posedge pclk) disable iff (!presetn)
      clk_en && end_of_travel && !power_up_launch &&
      !(cmd_wr && (cmd == CMD_RUN || cmd == CMD_RUN_VAR))
      |=> ended;
   endproperty
   a_limit: assert property (p_limit)
      else $error("limit did not set ended");
   property p_no_bad_launch;
      @(posedge pclk) disable iff (!presetn)
      clk_en && bad_loop && !started |=> !started;
   endproperty
   a_no_bad_launch: assert property (p_no_bad_launch)
      else $error("bad sequence launched");
   property p_halt_stream;
      @(posedge pclk) disable iff (!presetn)
      clk_en && cmd_wr && cmd == CMD_HALT && stream |=> !decel_req;
   endproperty
   a_halt_stream: assert property (p_halt_stream)
      else $error("halt acted in streaming mode");
   property p_halt_flush;
      @(posedge pclk) disable iff (!presetn)
      clk_en && cmd_wr && cmd == CMD_HALT && !stream
      |=> decel_req && flush_queue == !$past(ctrl[0]);
   endproperty
   a_halt_flush: assert property (p_halt_flush)
      else $error("halt flush wrong");
   property p_flag_keep;
      @(posedge pclk) disable iff (!presetn)
      clk_en && cmd_wr && cmd == CMD_FLAG_WRITE && pat_len == 4'd0
      |=> $stable(user_flag);
   endproperty
   a_flag_keep: assert property (p_flag_keep)
      else $error("omitted flags changed");
   property p_panel;
      @(posedge pclk) disable iff (!presetn)
      clk_en && fault_code == `FAULT_SHUT |=> !panel_fault;
   endproperty
   a_panel: assert property (p_panel)
      else $error("shutdown shown on panel");
   property p_reply_end;
      @(posedge pclk) disable iff (!presetn)
      reply_valid && reply_char == `CH_CR && reply_ready && clk_en
      |=> !reply_valid;
   endproperty
   a_reply_end: assert property (p_reply_end)
      else $error("reply not ended at carriage return");
endmodule

// ### verilog/seq_status_params.svh
// Constants of the sequence status and flag logic
// How it works
// - Unbalanced loop count in a sequence reports the bad-loop character.
// - Loop opened in one sequence and closed in another is invalid.
// - Sequence with unclosed nested loops is never launched.
// - Started set when run, run variant or power-up launches a sequence.
// - Started cleared by end marker, stop, kill or a travel limit.
// - Ended set by end marker, stop, kill or end-of-travel limit.
// - Ended cleared whenever a sequence is launched.
// - Fault query returns 00 none, 20 position, 22 current; panel shown.
// - Fault 23 for missing enable plug, 30 for checksum; panel shown.
// - Fault 60 for serial shutdown, not shown on panel.
// - Non-indexer variant reports 61 for incoming step pulses, shown.
// - Revision reply is asterisk, part number, suffix, carriage return.
// - Halt decelerates using the last programmed acceleration.
// - Halt normally discards the remaining command buffer.
// - With keep-buffer set, halt ends only the current move.
// - Halt ignored in streamed-velocity mode; exit-streaming stops it.
// - Long-form save behaves exactly like short-form save.
// - Eight user flags; pattern 0 clears, 1 sets, X keeps.
// - First pattern character is flag 8; omitted positions act as X.
// - Flag test runs following commands to end marker only on match.
// - Status reply is asterisk, @ A B C or D, carriage return.
// - Launch sets started, clears ended; completion does the reverse.
`ifndef SEQ_STATUS_PARAMS_SVH
`define SEQ_STATUS_PARAMS_SVH
`define REG_CTRL 12'h000
`define REG_CMD 12'h004
`define REG_FLAG_PAT 12'h008
`define REG_FLAG_MASK 12'h00C
`define REG_STATUS 12'h010
`define REG_FAULT_IN 12'h014
`define REG_REPLY 12'h018
`define REG_LOOP 12'h01C
`define REG_SAVE_CNT 12'h020
`define CTRL_KEEP_BIT 0
`define CTRL_NONIDX_BIT 1
`define CTRL_STREAM_BIT 2
`define CH_STAR 8'h2A
`define CH_CR 8'h0D
`define CH_AT 8'h40
`define CH_BADLOOP 8'h44
`define FAULT_NONE 8'h00
`define FAULT_POS 8'h20
`define FAULT_CUR 8'h22
`define FAULT_PLUG 8'h23
`define FAULT_CSUM 8'h30
`define FAULT_SHUT 8'h60
`define FAULT_STEP 8'h61
`define REV_LEN 5'd16
`endif

// ### verilog/seq_status_pkg.sv
// Types of the sequence status and flag logic
package seq_status_pkg;
   typedef enum logic [3:0] {
      CMD_NONE = 4'h0,
      CMD_RUN = 4'h1,
      CMD_RUN_VAR = 4'h2,
      CMD_STOP = 4'h3,
      CMD_KILL = 4'h4,
      CMD_END_MARK = 4'h5,
      CMD_HALT = 4'h6,
      CMD_EXIT_STREAM = 4'h7,
      CMD_SAVE = 4'h8,
      CMD_SAVE_LONG = 4'h9,
      CMD_FLAG_WRITE = 4'hA,
      CMD_FLAG_TEST = 4'hB,
      CMD_END_COND = 4'hC,
      CMD_Q_STATE = 4'hD,
      CMD_Q_FAULT = 4'hE,
      CMD_Q_REV = 4'hF
   } cmd_t;
   typedef enum logic [1:0] {
      RP_IDLE = 2'b00,
      RP_SEND = 2'b01
   } reply_state_t;
endpackage
